// [tucr_regs.svh]
// Register offsets, field positions and reset values of the trace unit config block
`ifndef TUCR_REGS_SVH
`define TUCR_REGS_SVH

`define TUCR_OFS_ENABLE       12'h004
`define TUCR_OFS_CORE_SEL     12'h008
`define TUCR_OFS_STATE        12'h00c
`define TUCR_OFS_OPTIONS      12'h010
`define TUCR_OFS_EVT_SEL      12'h020
`define TUCR_OFS_EVT_BEH      12'h024

`define TUCR_CORE_SEL_W       5
`define TUCR_EVT_SEL_W        8

`define TUCR_OPT_LOAD_P0      0
`define TUCR_OPT_STORE_P0     1
`define TUCR_OPT_BB           3
`define TUCR_OPT_CCI          4
`define TUCR_OPT_CID          6
`define TUCR_OPT_VIRTUAL_CONTEXT_ID_EN         7
`define TUCR_OPT_COND_LO      8
`define TUCR_OPT_TS           11
`define TUCR_OPT_RS           12
`define TUCR_OPT_QE_LO        13
`define TUCR_OPT_VIRTUAL_ID_SOURCE_SEL      15
`define TUCR_OPT_DA           16
`define TUCR_OPT_DV           17
`define TUCR_OPT_MASK         32'h0003ffdb

`define TUCR_BEH_INST_LO      0
`define TUCR_BEH_DATA         4
`define TUCR_BEH_TRIG         11
`define TUCR_BEH_LPO          12
`define TUCR_BEH_MASK         32'h0000181f

`define TUCR_RESET_VALUE      32'h00000000
`define TUCR_IDLE_SETTLE      4'h3

`endif

// [tucr_pkg.sv]
// Types shared by the trace unit config block
package tucr_pkg;

   typedef struct packed {
      logic       load_as_p0;
      logic       store_as_p0;
      logic       branch_broadcast_en;
      logic       cycle_count_en;
      logic       context_id_en;
      logic       virtual_context_id_en;
      logic [2:0] cond_mode;
      logic       global_timestamp_en;
      logic       return_stack_en;
      logic [1:0] q_element_sel;
      logic       virtual_id_source_sel;
      logic       data_address_trace_en;
      logic       data_value_trace_en;
   } tucr_opts_t;

   typedef struct packed {
      logic [3:0] instr_event_en;
      logic       data_event_en;
      logic       trigger_en;
      logic       low_power_override;
   } tucr_beh_t;

   typedef enum logic [1:0] {
      TUCR_IDLE    = 2'b00,
      TUCR_RUN     = 2'b01,
      TUCR_DRAIN   = 2'b11
   } tucr_mode_t;

endpackage : tucr_pkg

// [tucr_apb_slave.sv]
// APB slave front end: decodes one-cycle accesses for the register file
`timescale 1ns/1ps
`default_nettype none

module tucr_apb_slave
(
   input  wire logic        psel,       // Slave select
   input  wire logic        penable,    // Access phase
   input  wire logic        pwrite,     // Write direction
   input  wire logic [11:0] paddr,      // Byte address
   input  wire logic [31:0] rd_data,    // Read data from register file
   input  wire logic        hit,        // Address is mapped
   output logic             pready,     // Always ready
   output logic             pslverr,    // Unmapped address
   output logic [31:0]      prdata,     // Read data
   output logic             wr_stb,     // Write strobe
   output logic [11:0]      reg_addr    // Word-aligned address
);
   // Zero wait states; data path is combinational, held stable by master
   assign reg_addr = {paddr[11:2], 2'b00};
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~hit;
   assign wr_stb   = psel & penable & pwrite & hit;
   assign prdata   = (psel & ~pwrite & hit) ? rd_data : 32'h00000000;
endmodule : tucr_apb_slave

`default_nettype wire

// [tucr_event_match.sv]
// Event matcher: compares the selected event number against the live event bus
`timescale 1ns/1ps
`default_nettype none

module tucr_event_match
(
   input  wire logic [255:0] events,     // Event inputs from resources
   input  wire logic [7:0]   sel,        // Selected event number
   input  wire logic         active,     // Trace enabled
   output logic              hit         // Selected event fired
);
   assign hit = active & events[sel];
endmodule : tucr_event_match

`default_nettype wire

// [tucr_top.sv]
// Trace unit configuration and status registers with APB access
// Functional notes
// - Core-select field picks which processing element is observed and traced.
// - Core select exists only when implemented core count is above zero.
// - Config writes are discarded while enabled or not idle.
// - Load-as-P0 set traces loads as P0 instructions.
// - Store-as-P0 set traces stores as P0 instructions.
// - Branch broadcast bit enables branch broadcast mode.
// - Cycle count bit adds cycle counting to instruction trace.
// - Context ID bit enables context identifier tracing.
// - Virtual context ID bit enables virtual context identifier tracing.
// - Event select names event 0..255 producing event elements per enables.
// - Event behaviour sets instruction, data, trigger and low-power handling.
// - With enable clear, all trace outputs except core select, virtual ID source and low-power override are inactive.
//
// Local design decision: register access over APB.
`include "tucr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tucr_top
#(
   parameter int unsigned IMPL_CORE_COUNT = 1     // Implemented core count
)
(
   input  wire logic         pclk,                  // Clock, 25 MHz
   input  wire logic         presetn,               // Async reset, active low
   input  wire logic         psel,                  // APB select
   input  wire logic         penable,               // APB enable
   input  wire logic         pwrite,                // APB direction
   input  wire logic [11:0]  paddr,                 // APB address
   input  wire logic [31:0]  pwdata,                // APB write data
   output logic              pready,                // APB ready
   output logic              pslverr,               // APB error
   output logic [31:0]       prdata,                // APB read data
   input  wire logic         core_busy,             // Traced core pipeline has trace pending
   input  wire logic [255:0] events,                // Event inputs
   output logic              trace_active,          // Trace generation on
   output logic [4:0]        core_select_field,     // Observed core
   output logic              load_as_p0,            // Loads as P0
   output logic              store_as_p0,           // Stores as P0
   output logic              branch_broadcast_en,   // Branch broadcast
   output logic              cycle_count_en,        // Cycle counting
   output logic              context_id_en,         // Context ID trace
   output logic              virtual_context_id_en, // Virtual context ID trace
   output logic [2:0]        cond_mode,             // Conditional tracing
   output logic              global_timestamp_en,   // Timestamps
   output logic              return_stack_en,       // Return stack
   output logic [1:0]        q_element_sel,         // Q elements
   output logic              virtual_id_source_sel, // Virtual ID source
   output logic              data_address_trace_en, // Data address trace
   output logic              data_value_trace_en,   // Data value trace
   output logic [3:0]        instr_event_elem,      // Instruction event element
   output logic              data_event_elem,       // Data event element
   output logic              trace_bus_trigger,     // Trace bus trigger
   output logic              low_power_override     // Low-power override
);

   typedef struct packed {
      logic                        enable;
      logic [`TUCR_CORE_SEL_W-1:0] core_sel;
      tucr_pkg::tucr_opts_t        opts;
      logic [`TUCR_EVT_SEL_W-1:0]  evt_sel;
      tucr_pkg::tucr_beh_t         beh;
      tucr_pkg::tucr_mode_t        mode;
      logic [3:0]                  settle;
      logic                        stable;
      logic [3:0]                  ev_inst;
      logic                        ev_data;
      logic                        ev_trig;
   } tucr_state_t;

   tucr_state_t state;
   tucr_state_t next_state;

   logic        wr_stb;
   logic [11:0] reg_addr;
   logic        hit;
   logic [31:0] rd_data;
   logic        ev_hit;
   logic        idle;
   logic        cfg_ok;
   logic        has_core_sel;

   assign has_core_sel = (IMPL_CORE_COUNT > 0);
   assign idle         = (state.mode == tucr_pkg::TUCR_IDLE);
   assign cfg_ok       = ~state.enable & idle;

   always_comb
   begin
      hit = 1'b1;
      case (reg_addr)
         `TUCR_OFS_ENABLE, `TUCR_OFS_STATE, `TUCR_OFS_OPTIONS,
         `TUCR_OFS_EVT_SEL, `TUCR_OFS_EVT_BEH : hit = 1'b1;
         `TUCR_OFS_CORE_SEL : hit = has_core_sel;
         default : hit = 1'b0;
      endcase
   end

   tucr_apb_slave u_apb
   (
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .rd_data  (rd_data),
      .hit      (hit),
      .pready   (pready),
      .pslverr  (pslverr),
      .prdata   (prdata),
      .wr_stb   (wr_stb),
      .reg_addr (reg_addr)
   );

   tucr_event_match u_evt
   (
      .events (events),
      .sel    (state.evt_sel),
      .active (state.enable),
      .hit    (ev_hit)
   );

   always_comb
   begin
      rd_data = 32'h00000000;
      case (reg_addr)
         `TUCR_OFS_ENABLE   : rd_data[0] = state.enable;
         `TUCR_OFS_CORE_SEL : rd_data[`TUCR_CORE_SEL_W-1:0] = state.core_sel;
         `TUCR_OFS_STATE    : rd_data[1:0] = {state.stable, idle};
         `TUCR_OFS_OPTIONS  :
         begin
            rd_data[`TUCR_OPT_LOAD_P0]          = state.opts.load_as_p0;
            rd_data[`TUCR_OPT_STORE_P0]         = state.opts.store_as_p0;
            rd_data[`TUCR_OPT_BB]               = state.opts.branch_broadcast_en;
            rd_data[`TUCR_OPT_CCI]              = state.opts.cycle_count_en;
            rd_data[`TUCR_OPT_CID]              = state.opts.context_id_en;
            rd_data[`TUCR_OPT_VIRTUAL_CONTEXT_ID_EN]             = state.opts.virtual_context_id_en;
            rd_data[`TUCR_OPT_COND_LO+:3]       = state.opts.cond_mode;
            rd_data[`TUCR_OPT_TS]               = state.opts.global_timestamp_en;
            rd_data[`TUCR_OPT_RS]               = state.opts.return_stack_en;
            rd_data[`TUCR_OPT_QE_LO+:2]         = state.opts.q_element_sel;
            rd_data[`TUCR_OPT_VIRTUAL_ID_SOURCE_SEL]          = state.opts.virtual_id_source_sel;
            rd_data[`TUCR_OPT_DA]               = state.opts.data_address_trace_en;
            rd_data[`TUCR_OPT_DV]               = state.opts.data_value_trace_en;
         end
         `TUCR_OFS_EVT_SEL  : rd_data[`TUCR_EVT_SEL_W-1:0] = state.evt_sel;
         `TUCR_OFS_EVT_BEH  :
         begin
            rd_data[`TUCR_BEH_INST_LO+:4] = state.beh.instr_event_en;
            rd_data[`TUCR_BEH_DATA]       = state.beh.data_event_en;
            rd_data[`TUCR_BEH_TRIG]       = state.beh.trigger_en;
            rd_data[`TUCR_BEH_LPO]        = state.beh.low_power_override;
         end
         default : rd_data = 32'h00000000;
      endcase
   end

   always_comb
   begin
      next_state = state;
      // Idle tracks enable plus a short drain so in-flight trace finishes
      case (state.mode)
         tucr_pkg::TUCR_IDLE :
            if (state.enable)
               next_state.mode = tucr_pkg::TUCR_RUN;
         tucr_pkg::TUCR_RUN :
            if (!state.enable)
            begin
               next_state.mode   = tucr_pkg::TUCR_DRAIN;
               next_state.settle = `TUCR_IDLE_SETTLE;
            end
         tucr_pkg::TUCR_DRAIN :
            if (state.enable)
               next_state.mode = tucr_pkg::TUCR_RUN;
            else if (state.settle == 4'h0 && !core_busy)
               next_state.mode = tucr_pkg::TUCR_IDLE;
            else if (state.settle != 4'h0)
               next_state.settle = state.settle - 4'h1;
         default : next_state.mode = tucr_pkg::TUCR_IDLE;
      endcase
      if (wr_stb)
      begin
         if (reg_addr == `TUCR_OFS_ENABLE)
            next_state.enable = pwdata[0];
         if (cfg_ok)
         begin
            case (reg_addr)
               `TUCR_OFS_CORE_SEL :
                  next_state.core_sel = pwdata[`TUCR_CORE_SEL_W-1:0];
               `TUCR_OFS_OPTIONS :
               begin
                  next_state.opts.load_as_p0            = pwdata[`TUCR_OPT_LOAD_P0];
                  next_state.opts.store_as_p0           = pwdata[`TUCR_OPT_STORE_P0];
                  next_state.opts.branch_broadcast_en   = pwdata[`TUCR_OPT_BB];
                  next_state.opts.cycle_count_en        = pwdata[`TUCR_OPT_CCI];
                  next_state.opts.context_id_en         = pwdata[`TUCR_OPT_CID];
                  next_state.opts.virtual_context_id_en = pwdata[`TUCR_OPT_VIRTUAL_CONTEXT_ID_EN];
                  next_state.opts.cond_mode             = pwdata[`TUCR_OPT_COND_LO+:3];
                  next_state.opts.global_timestamp_en   = pwdata[`TUCR_OPT_TS];
                  next_state.opts.return_stack_en       = pwdata[`TUCR_OPT_RS];
                  next_state.opts.q_element_sel         = pwdata[`TUCR_OPT_QE_LO+:2];
                  next_state.opts.virtual_id_source_sel = pwdata[`TUCR_OPT_VIRTUAL_ID_SOURCE_SEL];
                  next_state.opts.data_address_trace_en = pwdata[`TUCR_OPT_DA];
                  next_state.opts.data_value_trace_en   = pwdata[`TUCR_OPT_DV];
               end
               `TUCR_OFS_EVT_SEL :
                  next_state.evt_sel = pwdata[`TUCR_EVT_SEL_W-1:0];
               `TUCR_OFS_EVT_BEH :
               begin
                  next_state.beh.instr_event_en     = pwdata[`TUCR_BEH_INST_LO+:4];
                  next_state.beh.data_event_en      = pwdata[`TUCR_BEH_DATA];
                  next_state.beh.trigger_en         = pwdata[`TUCR_BEH_TRIG];
                  next_state.beh.low_power_override = pwdata[`TUCR_BEH_LPO];
               end
               default : next_state.core_sel = state.core_sel;
            endcase
         end
      end

      // Stable drops with the enable write itself, not one cycle later
      next_state.stable = (next_state.mode == tucr_pkg::TUCR_IDLE) && !next_state.enable;

      // Event elements are one-cycle pulses, gated by the enable
      next_state.ev_inst = {4{ev_hit}} & state.beh.instr_event_en;
      next_state.ev_data = ev_hit & state.beh.data_event_en;
      next_state.ev_trig = ev_hit & state.beh.trigger_en;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   logic en;
   assign en = state.enable;

   // Options except core select and virtual ID source reach the trace logic only while tracing is on
   assign trace_active          = en;
   assign core_select_field     = state.core_sel;
   assign load_as_p0            = en & state.opts.load_as_p0;
   assign store_as_p0           = en & state.opts.store_as_p0;
   assign branch_broadcast_en   = en & state.opts.branch_broadcast_en;
   assign cycle_count_en        = en & state.opts.cycle_count_en;
   assign context_id_en         = en & state.opts.context_id_en;
   assign virtual_context_id_en = en & state.opts.virtual_context_id_en;
   assign cond_mode             = en ? state.opts.cond_mode : 3'h0;
   assign global_timestamp_en   = en & state.opts.global_timestamp_en;
   assign return_stack_en       = en & state.opts.return_stack_en;
   assign q_element_sel         = en ? state.opts.q_element_sel : 2'h0;
   assign virtual_id_source_sel = state.opts.virtual_id_source_sel;
   assign data_address_trace_en = en & state.opts.data_address_trace_en;
   assign data_value_trace_en   = en & state.opts.data_value_trace_en;
   assign instr_event_elem      = en ? state.ev_inst : 4'h0;
   assign data_event_elem       = en & state.ev_data;
   assign trace_bus_trigger     = en & state.ev_trig;
   assign low_power_override    = state.beh.low_power_override;

endmodule : tucr_top

`default_nettype wire

// [tucr_top_props.sv]
// Concurrent checks on the ports of the trace unit config registers
`timescale 1ns/1ps
`default_nettype none

module tucr_top_props
#(
   parameter int unsigned IMPL_CORE_COUNT = 1   // Implemented core count
)
(
   input wire logic         pclk,                  // Clock
   input wire logic         presetn,               // Async reset, active low
   input wire logic         psel,                  // APB select
   input wire logic         penable,               // APB enable
   input wire logic         pwrite,                // APB direction
   input wire logic [11:0]  paddr,                 // APB address
   input wire logic         pready,                // APB ready
   input wire logic         pslverr,               // APB error
   input wire logic [31:0]  prdata,                // APB read data
   input wire logic [255:0] events,                // Event inputs
   input wire logic         trace_active,          // Trace on
   input wire logic [4:0]   core_select_field,     // Observed core
   input wire logic         load_as_p0,            // Option
   input wire logic         store_as_p0,           // Option
   input wire logic         branch_broadcast_en,   // Option
   input wire logic         cycle_count_en,        // Option
   input wire logic         context_id_en,         // Option
   input wire logic         virtual_context_id_en, // Option
   input wire logic [2:0]   cond_mode,             // Option
   input wire logic         global_timestamp_en,   // Option
   input wire logic         return_stack_en,       // Option
   input wire logic [1:0]   q_element_sel,         // Option
   input wire logic         data_address_trace_en, // Option
   input wire logic         data_value_trace_en,   // Option
   input wire logic [3:0]   instr_event_elem,      // Event pulse
   input wire logic         data_event_elem,       // Event pulse
   input wire logic         trace_bus_trigger      // Event pulse
);
   wire logic [19:0] opt_vec = {load_as_p0, store_as_p0, branch_broadcast_en, cycle_count_en,
      context_id_en, virtual_context_id_en, cond_mode, global_timestamp_en, return_stack_en,
      q_element_sel, data_address_trace_en, data_value_trace_en, core_select_field};
   wire logic        pulses  = |{instr_event_elem, data_event_elem, trace_bus_trigger};
   wire logic        acc     = psel && penable;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_reset_zero; $rose(presetn) |-> !trace_active && opt_vec == 20'h0; endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");
   property p_gated; !trace_active |-> opt_vec[19:5] == 15'h0; endproperty
   a_gated: assert property (p_gated) else $error("option live while disabled");
   property p_quiet; !trace_active && !$past(trace_active) |-> !pulses; endproperty
   a_quiet: assert property (p_quiet) else $error("event pulse while disabled");
   property p_cause; pulses |-> $past(|events); endproperty
   a_cause: assert property (p_cause) else $error("event pulse without event");
   property p_frozen; trace_active && $past(trace_active) |-> $stable(opt_vec); endproperty
   a_frozen: assert property (p_frozen) else $error("config changed while enabled");
   property p_sel_cause;
      $changed(core_select_field) |-> $past(acc && pwrite && paddr == 12'h008 && !trace_active);
   endproperty
   a_sel_cause: assert property (p_sel_cause) else $error("core select changed unasked");
   property p_ready; psel |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready low in transfer");
   property p_unmapped; acc && paddr == 12'h100 |-> pslverr && prdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_sel_mapped; acc && paddr == 12'h008 |-> pslverr == (IMPL_CORE_COUNT == 0); endproperty
   a_sel_mapped: assert property (p_sel_mapped) else $error("core select presence wrong");
   property p_unstable;
      acc && !pwrite && paddr == 12'h00c && trace_active |-> prdata[1] == 1'b0;
   endproperty
   a_unstable: assert property (p_unstable) else $error("stable flag set while enabled");

   c_evt: cover property (data_event_elem);
   c_all: cover property (&instr_event_elem && trace_bus_trigger);
   c_off: cover property ($fell(trace_active));
endmodule : tucr_top_props

bind tucr_top tucr_top_props #(.IMPL_CORE_COUNT(IMPL_CORE_COUNT)) tucr_top_props_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata, .events, .trace_active,
   .core_select_field, .load_as_p0, .store_as_p0, .branch_broadcast_en, .cycle_count_en,
   .context_id_en, .virtual_context_id_en, .cond_mode, .global_timestamp_en, .return_stack_en,
   .q_element_sel, .data_address_trace_en, .data_value_trace_en, .instr_event_elem,
   .data_event_elem, .trace_bus_trigger);
`default_nettype wire

// [tucr_core_model.sv]
// Traced core model: event pulses on request, pipeline drain after trace stops
`timescale 1ns/1ps
`default_nettype none

module tucr_core_model
(
   input  wire logic         pclk,          // Clock
   input  wire logic         presetn,       // Async reset, active low
   input  wire logic         trace_active,  // Trace on
   input  wire logic         fire,          // Raise one event next cycle
   input  wire logic [7:0]   fire_num,      // Event number to raise
   input  wire logic [3:0]   drain_len,     // Drain cycles, 0 answers promptly
   output logic [255:0]      events,        // Event levels
   output logic              core_busy      // Trace still pending
);
   logic [3:0] cnt;

   assign core_busy = cnt != 4'h0;

   // Busy reloads while tracing so a slow drain starts when trace stops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         events <= '0;
         cnt    <= 4'h0;
      end
      else
      begin
         events <= fire ? (256'h1 << fire_num) : '0;
         cnt    <= trace_active ? drain_len : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
      end
   end
endmodule : tucr_core_model
`default_nettype wire

// [test_trace_unit_config_regs.sv]
// Self-checking bench for the trace unit config registers
`include "tucr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_trace_unit_config_regs;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rnd;
   logic pready, pslverr, core_busy, trace_active, fire_req = 1'b0;
   logic [255:0] events;
   logic [7:0] fire_num = 8'h00;
   logic [3:0] drain_len = 4'h0, instr_event_elem;
   logic [4:0] core_select_field;
   logic [2:0] cond_mode;
   logic [1:0] q_element_sel;
   logic load_as_p0, store_as_p0, branch_broadcast_en, cycle_count_en, context_id_en;
   logic virtual_context_id_en, global_timestamp_en, return_stack_en, virtual_id_source_sel;
   logic data_address_trace_en, data_value_trace_en, data_event_elem, trace_bus_trigger;
   logic low_power_override;
   int miscompares = 0, cmp_count = 0, m_reg[int];
   bit m_en = 1'b0, m_idle = 1'b0;
   int cfg[4] = '{32'h8, 32'h10, 32'h20, 32'h24};
   wire logic [31:0] opt_seen = {14'h0, data_value_trace_en, data_address_trace_en,
      virtual_id_source_sel, q_element_sel, return_stack_en, global_timestamp_en, cond_mode,
      virtual_context_id_en, context_id_en, 1'b0, cycle_count_en, branch_broadcast_en, 1'b0,
      store_as_p0, load_as_p0};
   wire logic [31:0] beh_seen = {19'h0, low_power_override, trace_bus_trigger, 6'h0,
      data_event_elem, instr_event_elem};

   tucr_top #(.IMPL_CORE_COUNT(1)) tucr_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata, .core_busy, .events, .trace_active,
      .core_select_field, .load_as_p0, .store_as_p0, .branch_broadcast_en, .cycle_count_en,
      .context_id_en, .virtual_context_id_en, .cond_mode, .global_timestamp_en, .return_stack_en,
      .q_element_sel, .virtual_id_source_sel, .data_address_trace_en, .data_value_trace_en,
      .instr_event_elem, .data_event_elem, .trace_bus_trigger, .low_power_override);
   tucr_core_model tucr_core_model_inst (.pclk, .presetn, .trace_active, .fire(fire_req),
      .fire_num, .drain_len, .events, .core_busy);

   always #20 pclk = ~pclk;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   function automatic int mask(input int a);
      case (a)
         32'h4: return 32'h1;
         32'h8: return 32'h1f;
         32'hc: return 32'h3;
         32'h10: return `TUCR_OPT_MASK;
         32'h20: return 32'hff;
         32'h24: return `TUCR_BEH_MASK;
         default: return 32'h0;
      endcase
   endfunction : mask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   // Request held from setup until ready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      if (a == 12'h004)
         m_en = d[0];
      else if (a != 12'h00c && !m_en && m_idle)
         m_reg[a] = d & mask(a);
   endtask : wr

   task automatic rdchk(input logic [11:0] a);
      logic [31:0] r, x;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      x = m_reg.exists(a) ? m_reg[a] : 32'h0;
      if (a == 12'h004)
         x = {31'h0, m_en};
      if (a == 12'h00c)
         x = {30'h0, m_idle && !m_en, m_idle};
      chk("read data", r, x);
      chk("read error", {31'h0, e}, {31'h0, mask(a) == 0});
   endtask : rdchk

   task automatic wait_idle;
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, 12'h00c, 32'h0, r, e);
         n++;
      end while (r[0] !== 1'b1 && n < 40);
      m_idle = 1'b1;
      chk("status", r, 32'h3);
   endtask : wait_idle

   task automatic fire(input logic [7:0] num, input logic [31:0] x);
      @(posedge pclk);
      fire_req <= 1'b1;
      fire_num <= num;
      @(posedge pclk);
      fire_req <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("event outputs", beh_seen, x);
   endtask : fire

   initial
   begin
      rnd = 32'h1e942258;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (cfg[k]) rdchk(cfg[k][11:0]);
      wait_idle();
      for (int i = 0; i < 6; i++)
      begin
         // Last pass uses all ones: event 255 and every field at its top value
         foreach (cfg[k])
         begin
            rnd = lfsr(rnd);
            wr(cfg[k][11:0], i == 5 ? 32'hffffffff : rnd);
         end
         foreach (cfg[k]) rdchk(cfg[k][11:0]);
         wr(12'h004, 32'h1);
         m_idle = 1'b0;
         repeat (2) @(posedge pclk);
         chk("options", opt_seen, m_reg[32'h10]);
         chk("core select", {27'h0, core_select_field}, m_reg[32'h8]);
         chk("trace on", {31'h0, trace_active}, {31'h0, m_en});
         rdchk(12'h00c);
         wr(12'h010, ~m_reg[32'h10]);
         rdchk(12'h010);
         fire(m_reg[32'h20][7:0], m_reg[32'h24] & 32'h181f);
         fire(8'(m_reg[32'h20] + 1), m_reg[32'h24] & 32'h1000);
         // Drain outlasts the core select write below, so it meets a busy unit
         drain_len <= 4'h8 + {1'b0, rnd[2:0]};
         wr(12'h004, 32'h0);
         rdchk(12'h00c);
         wr(12'h008, rnd);
         rdchk(12'h008);
         chk("gated options", opt_seen, m_reg[32'h10] & 32'h8000);
         fire(m_reg[32'h20][7:0], m_reg[32'h24] & 32'h1000);
         wait_idle();
      end
      wr(12'h00c, 32'h0);
      rdchk(12'h00c);
      rdchk(12'h100);
      results();
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      results();
   end
endmodule : test_trace_unit_config_regs
`default_nettype wire
